// >>> sac_pkg.sv
package sac_pkg;

  // ==========================================================================
  // Register map: printed offsets are word indices, byte address is 4 x index.
  // ==========================================================================
  localparam int unsigned REG_IDX_W  = 6;
  localparam logic [5:0]  IDX_CTRL1  = 6'h1c;
  localparam logic [5:0]  IDX_CTRL2  = 6'h1d;
  localparam logic [5:0]  IDX_RES_LO = 6'h1e;
  localparam logic [5:0]  IDX_RES_HI = 6'h1f;

  // ==========================================================================
  // Values after reset and after a standby entry.
  // ==========================================================================
  localparam logic [7:0]  CTRL1_RST  = 8'h10;
  localparam logic [5:0]  CTRL2_RST  = 6'h00;
  localparam logic [9:0]  RESULT_RST = 10'h000;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int unsigned START_BIT   = 7;
  localparam int unsigned MODE_LSB    = 5;
  localparam int unsigned AIN_DIS_BIT = 4;
  localparam int unsigned CH_LSB      = 0;
  localparam int unsigned LADDER_BIT  = 5;
  localparam int unsigned TIME_LSB    = 1;
  localparam int unsigned DONE_BIT    = 5;
  localparam int unsigned BUSY_BIT    = 4;

  // ==========================================================================
  // Operating mode codes.
  // ==========================================================================
  localparam logic [1:0]  MODE_OFF    = 2'h0;
  localparam logic [1:0]  MODE_SINGLE = 2'h1;
  localparam logic [1:0]  MODE_REPEAT = 2'h3;

  // ==========================================================================
  // Conversion lengths in oscillator clocks (39, 78, 156, 312, 624, 1248).
  // ==========================================================================
  localparam int unsigned CONV_CNT_W = 11;
  localparam logic [10:0] CONV_CLK_0 = 11'h027;
  localparam logic [10:0] CONV_CLK_2 = 11'h04e;
  localparam logic [10:0] CONV_CLK_3 = 11'h09c;
  localparam logic [10:0] CONV_CLK_4 = 11'h138;
  localparam logic [10:0] CONV_CLK_5 = 11'h270;
  localparam logic [10:0] CONV_CLK_6 = 11'h4e0;
  localparam logic [10:0] CONV_NONE  = 11'h000;

  // Maps the time code to a length; reserved codes give zero, meaning no launch.
  function automatic logic [10:0] sac_conv_len(input logic [2:0] code);
    logic [10:0] len;
    len = CONV_NONE;
    unique case (code)
      3'h0: len = CONV_CLK_0;
      3'h2: len = CONV_CLK_2;
      3'h3: len = CONV_CLK_3;
      3'h4: len = CONV_CLK_4;
      3'h5: len = CONV_CLK_5;
      3'h6: len = CONV_CLK_6;
      default: len = CONV_NONE;
    endcase
    return len;
  endfunction

endpackage

// >>> sac_conv_if.sv
interface sac_conv_if
  import sac_pkg::*;
  ();
  logic                  start;
  logic                  abort;
  logic [CONV_CNT_W-1:0] len;
  logic                  busy;
  logic                  done;

  modport ctl (output start, output abort, output len, input busy, input done);
  modport seq (input start, input abort, input len, output busy, output done);
endinterface

// >>> sac_sequencer.sv
module sac_sequencer
  import sac_pkg::*;
  (
  input wire logic clk,
  input wire logic resetn,
  sac_conv_if.seq  conv
  );

  typedef enum logic {SEQ_IDLE, SEQ_CONVERT} sac_seq_state_t;

  sac_seq_state_t        state_q;
  logic [CONV_CNT_W-1:0] cnt_q;

  // ==========================================================================
  // Busy covers the whole count; done marks its final cycle unless aborted.
  // ==========================================================================
  assign conv.busy = (state_q == SEQ_CONVERT);
  assign conv.done = (state_q == SEQ_CONVERT) && (cnt_q == 11'h001) && !conv.abort;

  // A start taken on the done cycle reloads at once, so repeat mode loses no clock.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= SEQ_IDLE;
      cnt_q   <= CONV_NONE;
    end
    else if (conv.abort)
    begin
      state_q <= SEQ_IDLE;
      cnt_q   <= CONV_NONE;
    end
    else if (conv.start && (state_q == SEQ_IDLE || conv.done))
    begin
      state_q <= SEQ_CONVERT;
      cnt_q   <= conv.len;
    end
    else if (conv.done)
    begin
      state_q <= SEQ_IDLE;
      cnt_q   <= CONV_NONE;
    end
    else if (state_q == SEQ_CONVERT)
    begin
      cnt_q <= cnt_q - 11'h001;
    end
  end

endmodule

// >>> sac_result_store.sv
module sac_result_store
  import sac_pkg::*;
  (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clear,
  input  wire logic       capture,
  input  wire logic [9:0] raw_result,
  output logic      [9:0] result_q
  );

  logic [9:0] meta_q;
  logic [9:0] sync_q;

  // ==========================================================================
  // The analog core settles on its own timing, so its word is synchronised.
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= RESULT_RST;
      sync_q <= RESULT_RST;
    end
    else
    begin
      meta_q <= raw_result;
      sync_q <= meta_q;
    end
  end

  // The stored word changes only at completion or a standby clear, so a late read still sees it.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      result_q <= RESULT_RST;
    else if (capture)
      result_q <= sync_q;
    else if (clear)
      result_q <= RESULT_RST;
  end

endmodule

// >>> sac_adc_control.sv
// Operation
// - Mode field: off, single start, reserved, repeat.
// - Start bit launches, then clears itself.
// - Channel field picks one of sixteen inputs.
// - Bit four set disables analog inputs.
// - Standby resets control registers, blocks writes.
// - Ladder bit keeps ladder always connected.
// - Time code sets conversion length in clocks.
// - Result split: high byte, two low bits.
// - Done flag read-only, cleared by high read.
// - Busy set at start, cleared at end/standby.
// - Low status bits three to zero meaningless.
// - Control two bits seven, six undefined.
// - Single mode start converts selected channel once.
// - Completion stores result, sets done, interrupts together.
// - Repeat restarts at once; mode off aborts.
// - New start clears done, keeps old result.
//
// Local design decision: the Avalon-MM slave port.
module sac_adc_control
  import sac_pkg::*;
  (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        standby_req,
  input  wire logic [9:0]  adc_result_in,
  output logic      [3:0]  channel_select,
  output logic             analog_in_disable,
  output logic             ladder_connect,
  output logic             conv_active,
  output logic             conv_done_irq
  );

  sac_conv_if conv ();

  logic [7:0]           ctrl1_q;
  logic [5:0]           ctrl2_q;
  logic                 done_q;
  logic                 irq_q;
  logic                 ladder_q;
  logic                 ack_q;
  logic [31:0]          rdata_q;
  logic [9:0]           result;
  logic [REG_IDX_W-1:0] idx;
  logic                 accept;
  logic                 wr_en;
  logic                 wr_ctrl1;
  logic                 wr_ctrl2;
  logic                 rd_high;
  logic [1:0]           conv_op_mode;
  logic [2:0]           time_code;
  logic                 cfg_valid;
  logic                 launch;
  logic                 relaunch;
  logic [7:0]           res_lo_view;

  // ==========================================================================
  // Bus slave: every access waits exactly one cycle, then completes.
  // ==========================================================================

  // One wait state gives a registered read path and a single edge for side effects.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read || avs_write) && !ack_q;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign accept          = (avs_read || avs_write) && ack_q;
  assign idx             = avs_address[7:2];

  // Standby blocks every write; only byte lane zero carries register data.
  assign wr_en    = avs_write && ack_q && avs_byteenable[0] && !standby_req;
  assign wr_ctrl1 = wr_en && (idx == IDX_CTRL1);
  assign wr_ctrl2 = wr_en && (idx == IDX_CTRL2);
  assign rd_high  = avs_read && ack_q && (idx == IDX_RES_HI);

  // The four unused low bits of the low register read as zero rather than noise.
  assign res_lo_view = {result[1:0], done_q, conv.busy, 4'h0};

  // Read data are captured in the wait cycle; unmapped words read as zero.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && !ack_q)
    begin
      unique case (idx)
        IDX_CTRL1:  rdata_q <= {24'h00_0000, ctrl1_q};
        IDX_CTRL2:  rdata_q <= {24'h00_0000, 2'h0, ctrl2_q};
        IDX_RES_LO: rdata_q <= {24'h00_0000, res_lo_view};
        IDX_RES_HI: rdata_q <= {24'h00_0000, result[9:2]};
        default:    rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

  // ==========================================================================
  // Control registers.
  // ==========================================================================
  assign conv_op_mode = ctrl1_q[MODE_LSB +: 2];
  assign time_code    = ctrl2_q[TIME_LSB +: 3];

  // Reserved codes behave as disabled until software writes a legal one.
  assign cfg_valid = ((conv_op_mode == MODE_SINGLE) || (conv_op_mode == MODE_REPEAT)) &&
                     (sac_conv_len(time_code) != CONV_NONE);

  // A software start is taken only while idle; a busy restart is dropped.
  assign launch   = ctrl1_q[START_BIT] && cfg_valid && !conv.busy;
  assign relaunch = conv.done && (conv_op_mode == MODE_REPEAT) && cfg_valid;

  // The start bit always reads back zero one cycle after it was written.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl1_q <= CTRL1_RST;
    else if (standby_req)
      ctrl1_q <= CTRL1_RST;
    else if (wr_ctrl1)
      ctrl1_q <= avs_writedata[7:0];
    else
      ctrl1_q[START_BIT] <= 1'b0;
  end

  // Bits seven and six are not stored; they always read back zero.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl2_q <= CTRL2_RST;
    else if (standby_req)
      ctrl2_q <= CTRL2_RST;
    else if (wr_ctrl2)
      ctrl2_q <= avs_writedata[5:0];
  end

  // ==========================================================================
  // Sequencer and result storage.
  // ==========================================================================
  assign conv.start = launch || relaunch;
  assign conv.abort = standby_req || !cfg_valid;
  assign conv.len   = sac_conv_len(time_code);

  sac_sequencer u_seq (
    .clk    (clk),
    .resetn (resetn),
    .conv   (conv)
  );

  // An aborted run never reaches done, so its partial value is never stored.
  sac_result_store u_res (
    .clk        (clk),
    .resetn     (resetn),
    .clear      (standby_req),
    .capture    (conv.done),
    .raw_result (adc_result_in),
    .result_q   (result)
  );

  // ==========================================================================
  // Status flags and interrupt.
  // ==========================================================================

  // Completion wins over a read or restart in the same cycle, so no event is lost.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      done_q <= 1'b0;
    else if (conv.done)
      done_q <= 1'b1;
    else if (standby_req || rd_high)
      done_q <= 1'b0;
    else if (launch)
      done_q <= 1'b0;
  end

  // One-cycle request, aligned with the done flag.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_q <= 1'b0;
    else
      irq_q <= conv.done;
  end

  // The ladder draws current, so it is off between runs unless held on.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ladder_q <= 1'b0;
    else
      ladder_q <= (ctrl2_q[LADDER_BIT] && !standby_req) || conv.start ||
                  (conv.busy && !conv.done && !conv.abort);
  end

  // ==========================================================================
  // Analog side outputs.
  // ==========================================================================
  assign channel_select    = ctrl1_q[CH_LSB +: 4];
  assign analog_in_disable = ctrl1_q[AIN_DIS_BIT];
  assign ladder_connect    = ladder_q;
  assign conv_active       = conv.busy;
  assign conv_done_irq     = irq_q;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  logic [CONV_CNT_W-1:0] chk_len_q;
  logic [CONV_CNT_W-1:0] chk_run_q;

  // Tracks the length of the run in progress and the cycles spent in it.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chk_len_q <= CONV_NONE;
      chk_run_q <= CONV_NONE;
    end
    else if (conv.start && (!conv.busy || conv.done) && !conv.abort)
    begin
      chk_len_q <= conv.len;
      chk_run_q <= 11'h001;
    end
    else if (conv.busy)
      chk_run_q <= chk_run_q + 11'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_launch;
    launch && !conv.abort;
  endsequence

  sequence s_complete;
    conv.done ##1 (done_q && conv_done_irq);
  endsequence

  // A run that is neither finishing nor being stopped in this cycle.
  sequence s_running;
    conv.busy && !conv.done && !conv.abort;
  endsequence

  // A run stopped by software rather than by a standby entry.
  sequence s_sw_abort;
    conv.busy && conv.abort && !standby_req;
  endsequence

  a_mode_reserved_idle: assert property (
    !cfg_valid |=> !conv.busy)
    else $error("Launch with reserved or disabled settings.");

  a_start_bit_clears: assert property (
    s_launch |=> (!ctrl1_q[START_BIT] && conv.busy))
    else $error("Start bit not cleared after launch.");

  a_standby_resets: assert property (
    standby_req |=> (ctrl1_q == CTRL1_RST && ctrl2_q == CTRL2_RST && !conv.busy))
    else $error("Standby did not restore control state.");

  a_ladder_on_busy: assert property (
    (conv.busy && !$rose(conv.busy) && !conv.done) |-> ladder_connect)
    else $error("Ladder disconnected during conversion.");

  a_conv_length: assert property (
    conv.done |-> (chk_run_q == chk_len_q))
    else $error("Conversion length differs from time code.");

  a_result_stored: assert property (
    conv.done |=> ((result == $past(u_res.sync_q)) && done_q && conv_done_irq))
    else $error("Completion did not store result and flag.");

  a_done_read_clear: assert property (
    (rd_high && !conv.done) |=> !done_q)
    else $error("Reading high result did not clear done.");

  a_busy_lifetime: assert property (
    s_running |=> conv.busy)
    else $error("Busy dropped early in a conversion.");

  a_repeat_chain: assert property (
    (conv.done && relaunch && !conv.abort) |-> s_complete ##0 conv.busy)
    else $error("Repeat mode did not chain the next run.");

  a_done_on_restart: assert property (
    (s_launch ##0 !conv.done) |=> (!done_q && $stable(result)))
    else $error("Restart did not clear done or lost result.");

  a_reserved_reads: assert property (
    (avs_read && ack_q && (idx == IDX_CTRL2 || idx == IDX_RES_LO)) |->
      (avs_readdata[31:8] == 24'h00_0000))
    else $error("Upper read data not zero.");

  // Completion hands back to idle unless repeat mode chains a new run.
  a_busy_ends: assert property (
    (conv.done && !conv.start) |=> !conv.busy)
    else $error("Busy stayed set after a single completion.");

  // The request is a pulse, so a level-sensitive controller sees one event.
  a_irq_one_cycle: assert property (
    conv_done_irq |=> !conv_done_irq)
    else $error("Completion request held longer than one cycle.");

  // The partial word of a stopped run must never reach the result registers.
  a_abort_discards: assert property (
    s_sw_abort |=> (!conv.busy && !conv_done_irq && $stable(result)))
    else $error("Stopped run completed or stored a result.");

  // Holding the ladder on trades idle current for a faster first sample.
  a_ladder_held: assert property (
    (ctrl2_q[LADDER_BIT] && !standby_req) |=> ladder_connect)
    else $error("Ladder dropped while held on.");

  // A start that does not launch is dropped, never kept pending.
  a_start_refused: assert property (
    (ctrl1_q[START_BIT] && !wr_ctrl1 && !standby_req) |=> !ctrl1_q[START_BIT])
    else $error("Start bit did not clear itself.");

  // Only a completion or a standby entry may touch the stored word.
  a_result_holds: assert property (
    (!conv.done && !standby_req) |=> $stable(result))
    else $error("Result changed without a completion.");

  // The done flag has no path other than a finished run.
  a_done_after_completion: assert property (
    $rose(done_q) |-> $past(conv.done))
    else $error("Done flag rose without a completion.");

  // The status word shows the busy flag as it stood when the read was taken.
  a_busy_readback: assert property (
    (avs_read && !ack_q && (idx == IDX_RES_LO)) |=>
      (avs_readdata[BUSY_BIT] == $past(conv.busy)))
    else $error("Busy flag read back wrong.");

endmodule

// >>> sac_analog_model.sv
// ==========================================================
// Analog core stand-in: sample-hold, comparator and ladder.
// ==========================================================
module sac_analog_model
  (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [3:0] channel_select,
  input  wire logic       conv_active,
  input  wire logic       conv_done_irq,
  output logic      [9:0] adc_result_in
  );
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] seq_q;

  // A held word carries the channel and a conversion number; while idle the word toggles
  // every cycle, so a stale sample can never pass for a fresh one.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seq_q         <= 4'h0;
      adc_result_in <= 10'h000;
    end
    else
    begin
      if (conv_done_irq)
        seq_q <= seq_q + 4'h1;
      if (conv_active)
        adc_result_in <= {channel_select, 2'h0, seq_q};
      else
        adc_result_in <= ~adc_result_in;
    end
  end
endmodule

// >>> sac_adc_control_tb_top.sv
// ==========================================================
// Bench for the converter control block.
// ==========================================================
module sac_adc_control_tb_top
  import sac_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        standby_req = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [9:0]  adc_result_in;
  logic [3:0]  channel_select;
  logic        analog_in_disable;
  logic        ladder_connect;
  logic        conv_active;
  logic        conv_done_irq;
  logic [31:0] rd_q;
  int          n_mismatch = 0;
  int          compares = 0;
  int          busy_tot = 0;
  int          idle_tot = 0;
  int          irq_tot = 0;

  sac_adc_control sac_adc_control_i (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .standby_req(standby_req),
    .adc_result_in(adc_result_in), .channel_select(channel_select),
    .analog_in_disable(analog_in_disable), .ladder_connect(ladder_connect),
    .conv_active(conv_active), .conv_done_irq(conv_done_irq));
  sac_analog_model sac_analog_model_i (.clk(clk), .resetn(resetn),
    .channel_select(channel_select), .conv_active(conv_active),
    .conv_done_irq(conv_done_irq), .adc_result_in(adc_result_in));

  // Clock at 10 MHz.
  always #50 clk = ~clk;

  // Outputs are counted mid-cycle, well clear of the edges that move them.
  // Only this block writes the totals; scenarios keep their own start marks.
  always @(negedge clk)
  begin
    busy_tot += (conv_active === 1'b1);
    idle_tot += (conv_active !== 1'b1);
    irq_tot += (conv_done_irq === 1'b1);
  end

  // ==========================================================
  // Shared tasks.
  // ==========================================================
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Samples waitrequest at each rising edge; read data are taken at the edge it is low.
  task automatic wait_ack();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      n_mismatch++;
      give_verdict();
    end
    rd_q = avs_readdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack();
    avs_read <= 1'b0;
    @(posedge clk);
    chk(what, {24'h0, exp}, rd_q);
  endtask

  // Waits for the busy flag to drop, with a bound above the longest conversion.
  task automatic wait_idle();
    int i;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end while (conv_active !== 1'b0 && i < 2000);
    if (conv_active !== 1'b0)
    begin
      n_mismatch++;
      give_verdict();
    end
    @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios.
  // ==========================================================
  task automatic t_reset();
    rchk("ctrl1", 8'h70, 8'h10);
    rchk("ctrl2", 8'h74, 8'h00);
    rchk("res_lo", 8'h78, 8'h00);
    rchk("res_hi", 8'h7c, 8'h00);
    wr(8'h40, 8'h55);
    rchk("unmapped", 8'h40, 8'h00);
    chk("ain_dis", 32'h1, {31'h0, analog_in_disable});
  endtask

  task automatic t_fields();
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h70, 8'(c));
      chk("channel", 32'(c), {28'h0, channel_select});
      chk("ain_dis", 32'h0, {31'h0, analog_in_disable});
    end
    wr(8'h74, 8'hff);
    rchk("ctrl2", 8'h74, 8'h3f);
    chk("ladder", 32'h1, {31'h0, ladder_connect});
    wr(8'h74, 8'h10);
    rchk("ctrl2", 8'h74, 8'h10);
    chk("ladder", 32'h0, {31'h0, ladder_connect});
  endtask

  // One software-started conversion, timed and read back in the safe order.
  task automatic t_single(input logic [2:0] tc, input int len, input logic [3:0] ch);
    logic [9:0] e;
    int         b0;
    int         q0;
    wr(8'h74, {4'h1, tc, 1'b0});
    wr(8'h70, {1'b0, MODE_SINGLE, 1'b0, ch});
    b0 = busy_tot;
    q0 = irq_tot;
    wr(8'h70, {1'b1, MODE_SINGLE, 1'b0, ch});
    rchk("start_clr", 8'h70, {1'b0, MODE_SINGLE, 1'b0, ch});
    wait_idle();
    chk("conv_len", 32'(len), busy_tot - b0);
    chk("irq", 32'h1, irq_tot - q0);
    e = {ch, 2'h0, 4'(irq_tot - 1)};
    rchk("res_lo", 8'h78, {e[1:0], 2'h2, 4'h0});
    rchk("res_hi", 8'h7c, e[9:2]);
    rchk("done_clr", 8'h78, {e[1:0], 2'h0, 4'h0});
  endtask

  // Restart before reading, then starts with reserved settings.
  task automatic t_keep();
    logic [9:0] o;
    int         b0;
    wr(8'h70, {1'b1, MODE_SINGLE, 1'b0, 4'h9});
    wait_idle();
    o = {4'h9, 2'h0, 4'(irq_tot - 1)};
    wr(8'h70, {1'b1, MODE_SINGLE, 1'b0, 4'ha});
    rchk("keep_lo", 8'h78, {o[1:0], 2'h1, 4'h0});
    rchk("keep_hi", 8'h7c, o[9:2]);
    wait_idle();
    b0 = busy_tot;
    wr(8'h70, 8'hc0);
    repeat (4) @(posedge clk);
    chk("rsv_mode", 32'h0, busy_tot - b0);
    for (int t = 1; t < 8; t += 6)
    begin
      wr(8'h74, {4'h1, 3'(t), 1'b0});
      wr(8'h70, {1'b1, MODE_SINGLE, 5'h0});
      repeat (4) @(posedge clk);
      chk("rsv_time", 32'h0, busy_tot - b0);
    end
  endtask

  task automatic t_repeat();
    logic [9:0] e;
    int         i;
    int         i0;
    int         q0;
    wr(8'h74, 8'h16);
    wr(8'h70, {1'b1, MODE_REPEAT, 1'b0, 4'h6});
    i0 = idle_tot;
    q0 = irq_tot;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end while (irq_tot - q0 < 3 && i < 600);
    @(posedge clk);
    chk("rpt_irq", 32'h3, irq_tot - q0);
    chk("rpt_gap", 32'h0, idle_tot - i0);
    wr(8'h70, {1'b0, MODE_OFF, 1'b0, 4'h6});
    wait_idle();
    repeat (50) @(posedge clk);
    chk("abort_irq", 32'h3, irq_tot - q0);
    e = {4'h6, 2'h0, 4'(irq_tot - 1)};
    rchk("abort_lo", 8'h78, {e[1:0], 2'h2, 4'h0});
    rchk("abort_hi", 8'h7c, e[9:2]);
  endtask

  task automatic t_standby();
    wr(8'h74, 8'h36);
    wr(8'h70, {1'b1, MODE_SINGLE, 1'b0, 4'h5});
    standby_req <= 1'b1;
    repeat (2) @(posedge clk);
    wr(8'h70, 8'h2f);
    rchk("sb_ctrl1", 8'h70, 8'h10);
    rchk("sb_ctrl2", 8'h74, 8'h00);
    rchk("sb_lo", 8'h78, 8'h00);
    rchk("sb_hi", 8'h7c, 8'h00);
    chk("sb_busy", 32'h0, {31'h0, conv_active});
    chk("sb_ladder", 32'h0, {31'h0, ladder_connect});
    standby_req <= 1'b0;
    @(posedge clk);
    wr(8'h70, 8'h2f);
    rchk("wake", 8'h70, 8'h2f);
  endtask

  // ==========================================================
  // Main sequence.
  // ==========================================================
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_fields();
    // Codes 000 and 010 are too short at a 10 MHz clock, so software skips them.
    t_single(3'h3, 156, 4'h0);
    t_single(3'h4, 312, 4'h3);
    t_single(3'h3, 156, 4'h7);
    t_single(3'h4, 312, 4'hc);
    t_single(3'h5, 624, 4'he);
    t_single(3'h6, 1248, 4'hf);
    t_keep();
    t_repeat();
    t_standby();
    give_verdict();
  end
endmodule
